// [src/asp_pkg.sv]
package asp_pkg;
	localparam int COMM_W   = 8;
	localparam int REG_W    = 24;
	localparam int SEL_W    = 3;
	localparam int SEL_LSB  = 3;
	localparam int RD_BIT   = 6;
	localparam int NREG     = 8;
	localparam int CNT_W    = 5;
	localparam logic [SEL_W-1:0] DATA_SEL = 3'h3;
	localparam logic [REG_W-1:0] REG_RST  = 24'h000000;
	localparam logic [CNT_W-1:0] COMM_LAST = 5'h07;
	localparam logic [CNT_W-1:0] DATA_LAST = 5'h17;
	localparam logic [2:0] SYNC_RST = 3'h7;

	typedef enum logic [1:0]
	{
		ASP_COMM  = 2'b00,
		ASP_WRITE = 2'b01,
		ASP_READ  = 2'b10
	} asp_state_t;
endpackage

// [src/asp_stream_if.sv]
`timescale 1ns/1ps
interface asp_stream_if #(parameter int W = 24);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [src/asp_buf2.sv]
`timescale 1ns/1ps
module asp_buf2 #(
	parameter int W     = 24,
	parameter int DEPTH = 2
) (
	input  wire logic clk,
	input  wire logic rst,
	asp_stream_if.snk in_s,
	asp_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	logic          in_rdy_r;
	logic          push;
	logic          pop;

	assign push = in_s.valid && in_rdy_r;
	assign pop = out_s.valid && out_s.ready;
	assign in_s.ready = in_rdy_r;
	assign out_s.valid = (cnt_r != '0);
	assign out_s.data = mem[rp_r];

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_r     <= '0;
			rp_r     <= '0;
			cnt_r    <= '0;
			in_rdy_r <= 1'b0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r    <= cnt_nxt;
			// ready is registered so the filter side sees a flop, not a path
			in_rdy_r <= (cnt_nxt != FULL);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= in_s.data;
	end
endmodule // asp_buf2

// [src/asp_port.sv]
// Function
// - sync low holds filter, calibration, modulator reset
// - sync never touches serial logic or shifters
// - sync low forces ready indication high
// - ready pin low when conversion completes
// - unread result: ready high before next update
// - output bit shifted out on falling clock
// - output shifter loads any data or control register
// - shifted-in word goes to selected control register
// - accept continuous or burst serial clock
`timescale 1ns/1ps
module asp_port #(
	parameter int REG_W = asp_pkg::REG_W,
	parameter int NREG  = asp_pkg::NREG
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              din,
	input  wire logic              filter_sync_n,
	output logic                   serial_out_ready_n,
	output logic                   serial_out_oe,
	output logic                   sync_hold,
	input  wire logic              conv_valid,
	input  wire logic [REG_W-1:0]  conv_data,
	output logic                   conv_ready,
	input  wire logic              update_soon,
	output logic [NREG*REG_W-1:0]  ctrl_regs
);
	logic [2:0]                 sclk_s_r;
	logic [2:0]                 cs_s_r;
	logic [2:0]                 din_s_r;
	logic [2:0]                 sync_s_r;
	logic                       sclk_f_r;
	logic                       cs_f_r;
	logic                       din_f_r;
	logic                       sync_f_r;
	logic                       sclk_rise;
	logic                       sclk_fall;
	logic                       sel_active;
	asp_pkg::asp_state_t        st_r;
	logic [asp_pkg::CNT_W-1:0]  bit_r;
	logic [REG_W-1:0]           sh_in_r;
	logic [REG_W-1:0]           sh_out_r;
	logic [asp_pkg::SEL_W-1:0]  sel_r;
	logic [REG_W-1:0]           regs_r [NREG];
	logic [REG_W-1:0]           last_data_r;
	logic                       rdy_n_r;
	logic                       dout_r;
	logic                       oe_r;
	logic                       hold_r;
	logic [asp_pkg::COMM_W-1:0] comm_byte;
	logic                       comm_done;
	logic                       data_done;
	logic                       data_pop;

	asp_stream_if #(.W(REG_W)) conv_in ();
	asp_stream_if #(.W(REG_W)) conv_out ();

	assign conv_in.valid = conv_valid;
	assign conv_in.data = conv_data;
	assign conv_ready = conv_in.ready;

	asp_buf2 #(.W(REG_W), .DEPTH(2)) i_asp_buf2 (
		.clk   (clk),
		.rst   (rst),
		.in_s  (conv_in),
		.out_s (conv_out)
	);

	// pins pass three flops; a level is taken once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			// idle level of the clock is high, so a released reset makes no false rise
			sclk_s_r <= 3'h7;
			cs_s_r   <= 3'h7;
			din_s_r  <= 3'h0;
			sync_s_r <= asp_pkg::SYNC_RST;
		end
		else
		begin
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			cs_s_r   <= {cs_s_r[1:0], cs_n};
			din_s_r  <= {din_s_r[1:0], din};
			sync_s_r <= {sync_s_r[1:0], filter_sync_n};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclk_f_r <= 1'b1;
			cs_f_r   <= 1'b1;
			din_f_r  <= 1'b0;
			sync_f_r <= 1'b1;
		end
		else
		begin
			if (sclk_s_r[2] == sclk_s_r[1])
				sclk_f_r <= sclk_s_r[2];
			if (cs_s_r[2] == cs_s_r[1])
				cs_f_r <= cs_s_r[2];
			if (din_s_r[2] == din_s_r[1])
				din_f_r <= din_s_r[2];
			if (sync_s_r[2] == sync_s_r[1])
				sync_f_r <= sync_s_r[2];
		end
	end

	// edge found when stages two and three agree against the filtered level, so a stalled clock between bursts is harmless
	assign sclk_rise = !sclk_f_r && sclk_s_r[2] && sclk_s_r[1];
	assign sclk_fall = sclk_f_r && !sclk_s_r[2] && !sclk_s_r[1];
	assign sel_active = !cs_f_r;
	assign comm_byte = {sh_in_r[asp_pkg::COMM_W-2:0], din_f_r};
	assign comm_done = sel_active && sclk_rise && (st_r == asp_pkg::ASP_COMM)
		&& (bit_r == asp_pkg::COMM_LAST);
	assign data_done = sel_active && sclk_rise && (st_r != asp_pkg::ASP_COMM)
		&& (bit_r == asp_pkg::DATA_LAST);
	assign data_pop = comm_done && comm_byte[asp_pkg::RD_BIT]
		&& (comm_byte[asp_pkg::SEL_LSB +: asp_pkg::SEL_W] == asp_pkg::DATA_SEL);
	assign conv_out.ready = data_pop;

	// serial engine: cleared only by reset or chip select, never by sync
	always_ff @(posedge clk)
	begin
		if (rst || cs_f_r)
		begin
			st_r  <= asp_pkg::ASP_COMM;
			bit_r <= '0;
			sel_r <= '0;
		end
		else if (sclk_rise)
		begin
			bit_r <= bit_r + 1'b1;
			case (st_r)
				asp_pkg::ASP_COMM:
				begin
					if (bit_r == asp_pkg::COMM_LAST)
					begin
						bit_r <= '0;
						sel_r <= comm_byte[asp_pkg::SEL_LSB +: asp_pkg::SEL_W];
						st_r  <= comm_byte[asp_pkg::RD_BIT] ? asp_pkg::ASP_READ
							: asp_pkg::ASP_WRITE;
					end
				end
				asp_pkg::ASP_WRITE, asp_pkg::ASP_READ:
				begin
					if (bit_r == asp_pkg::DATA_LAST)
					begin
						bit_r <= '0;
						st_r  <= asp_pkg::ASP_COMM;
					end
				end
				default:
				begin
					st_r  <= asp_pkg::ASP_COMM;
					bit_r <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			sh_in_r <= '0;
		else if (sel_active && sclk_rise)
			sh_in_r <= {sh_in_r[REG_W-2:0], din_f_r};
	end

	// a data read with an empty buffer repeats the last result
	always_ff @(posedge clk)
	begin
		if (rst)
			last_data_r <= asp_pkg::REG_RST;
		else if (data_pop && conv_out.valid)
			last_data_r <= conv_out.data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			sh_out_r <= '0;
		else if (comm_done)
		begin
			if (comm_byte[asp_pkg::SEL_LSB +: asp_pkg::SEL_W] == asp_pkg::DATA_SEL)
				sh_out_r <= conv_out.valid ? conv_out.data : last_data_r;
			else
				sh_out_r <= regs_r[comm_byte[asp_pkg::SEL_LSB +: asp_pkg::SEL_W]];
		end
		else if (sel_active && sclk_fall && st_r == asp_pkg::ASP_READ)
			sh_out_r <= {sh_out_r[REG_W-2:0], 1'b0};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < NREG; i++)
				regs_r[i] <= asp_pkg::REG_RST;
		end
		else if (data_done && st_r == asp_pkg::ASP_WRITE && sel_r != asp_pkg::DATA_SEL)
			regs_r[sel_r] <= {sh_in_r[REG_W-2:0], din_f_r};
	end

	always_comb
	begin
		for (int i = 0; i < NREG; i++)
			ctrl_regs[i*REG_W +: REG_W] = regs_r[i];
	end

	// sync beats a new result; a new result beats the update or read clear
	always_ff @(posedge clk)
	begin
		if (rst)
			rdy_n_r <= 1'b1;
		else if (!sync_f_r)
			rdy_n_r <= 1'b1;
		else if (conv_valid && conv_ready)
			rdy_n_r <= 1'b0;
		else if (update_soon || data_pop)
			rdy_n_r <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hold_r <= 1'b1;
		else
			hold_r <= !sync_f_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dout_r <= 1'b1;
			oe_r   <= 1'b0;
		end
		else
		begin
			oe_r <= sel_active;
			if (sel_active && st_r == asp_pkg::ASP_READ)
			begin
				if (sclk_fall)
					dout_r <= sh_out_r[REG_W-1];
			end
			else
				dout_r <= rdy_n_r;
		end
	end

	assign serial_out_ready_n = dout_r;
	assign serial_out_oe = oe_r;
	assign sync_hold = hold_r;
endmodule // asp_port

// [tb/asp_port_chk_sva.sv]
`timescale 1ns/1ps
module asp_port_chk (
	input wire logic                                     clk,
	input wire logic                                     rst,
	input wire logic                                     cs_n,
	input wire logic                                     filter_sync_n,
	input wire logic                                     serial_out_ready_n,
	input wire logic                                     serial_out_oe,
	input wire logic                                     sync_hold,
	input wire logic                                     conv_valid,
	input wire logic                                     conv_ready,
	input wire logic                                     update_soon,
	input wire logic [asp_pkg::NREG*asp_pkg::REG_W-1:0] ctrl_regs
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_hold_on: assert property ($fell(filter_sync_n) |-> ##[1:6] sync_hold)
		else $error("sync hold late");
	a_hold_off: assert property (filter_sync_n[*8] |-> !sync_hold)
		else $error("sync hold stuck");
	a_sync_rdy: assert property ((sync_hold && !serial_out_oe)[*2] |-> serial_out_ready_n)
		else $error("ready low in sync");
	a_oe_on: assert property ((!cs_n)[*6] |-> serial_out_oe)
		else $error("pin not driven");
	a_oe_off: assert property (cs_n[*6] |-> !serial_out_oe)
		else $error("pin driven unselected");
	a_rdy_low: assert property (conv_valid && conv_ready && cs_n && filter_sync_n && !sync_hold
		|-> ##[1:3] !serial_out_ready_n) else $error("ready not low");
	a_rdy_up: assert property (update_soon && cs_n |-> ##[1:3] serial_out_ready_n)
		else $error("ready not high");
	a_regs_hold: assert property (cs_n[*8] |=> $stable(ctrl_regs))
		else $error("register changed idle");
endmodule // asp_port_chk
bind asp_port asp_port_chk i_asp_port_chk (.*);

// [tb/asp_host.sv]
`timescale 1ns/1ps
module asp_host (
	input  wire logic clk,
	input  wire logic pin,
	input  wire logic pin_oe,
	output logic      sclk,
	output logic      cs_n,
	output logic      din
);
	logic last = 1'b0;
	// a released pin must not look like the last bit
	wire  line = pin_oe ? pin : ~last;
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	always @(negedge clk)
		if (pin_oe)
			last <= pin;
	// idle clock high; gap pauses after the command byte
	task automatic xfer(input logic [31:0] w, input int gap, output logic [23:0] rd);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int k = 31; k >= 0; k--)
		begin
			sclk = 1'b0;
			din  = w[k];
			repeat (4) @(negedge clk);
			// take the bit as the clock rises, where it must already be valid
			if (k < 24)
				rd[k] = line;
			sclk = 1'b1;
			repeat ((k == 24) ? gap : 0) @(negedge clk);
			repeat (4) @(negedge clk);
		end
		repeat (8) @(negedge clk);
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule // asp_host

// [tb/test_adc_serial_ready_sync_port.sv]
`timescale 1ns/1ps
module test_adc_serial_ready_sync_port;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         filter_sync_n = 1'b1;
	logic         conv_valid = 1'b0;
	logic [23:0]  conv_data = 24'h000000;
	logic         update_soon = 1'b0;
	logic         sclk, cs_n, din, rdy_n, oe, sync_hold, conv_ready;
	logic [191:0] ctrl_regs;
	logic [23:0]  rd;
	int           n_fail = 0;
	int           compares = 0;
	always #10 clk = ~clk;
	asp_port i_asp_port (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.filter_sync_n(filter_sync_n), .serial_out_ready_n(rdy_n), .serial_out_oe(oe),
		.sync_hold(sync_hold), .conv_valid(conv_valid), .conv_data(conv_data),
		.conv_ready(conv_ready), .update_soon(update_soon), .ctrl_regs(ctrl_regs));
	asp_host i_asp_host (.clk(clk), .pin(rdy_n), .pin_oe(oe), .sclk(sclk), .cs_n(cs_n),
		.din(din));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_rdy(input logic v);
		int i;
		for (i = 0; i < 20 && rdy_n !== v; i++)
			@(negedge clk);
		check(rdy_n, v);
		if (i == 20)
			test_done;
	endtask
	task automatic offer(input logic [23:0] d);
		check(conv_ready, 1'b1);
		conv_data  = d;
		conv_valid = 1'b1;
		@(negedge clk);
		conv_valid = 1'b0;
	endtask
	task automatic t_regs;
		i_asp_host.xfer({8'h08, 24'ha5c33c}, 0, rd);
		check(ctrl_regs[47:24], 24'ha5c33c);
		i_asp_host.xfer({8'h48, 24'h000000}, 6, rd);
		check(rd, 24'ha5c33c);
		i_asp_host.xfer({8'h18, 24'hffffff}, 0, rd);
		check(ctrl_regs[95:72], 24'h000000);
	endtask
	task automatic t_conv;
		offer(24'h123456);
		wait_rdy(1'b0);
		update_soon = 1'b1;
		@(negedge clk);
		update_soon = 1'b0;
		wait_rdy(1'b1);
		offer(24'h654321);
		wait_rdy(1'b0);
		check(conv_ready, 1'b0);
		i_asp_host.xfer({8'h58, 24'h000000}, 0, rd);
		check(rd, 24'h123456);
		check(rdy_n, 1'b1);
		i_asp_host.xfer({8'h58, 24'h000000}, 0, rd);
		check(rd, 24'h654321);
		// empty buffer repeats the last result
		i_asp_host.xfer({8'h58, 24'h000000}, 0, rd);
		check(rd, 24'h654321);
	endtask
	task automatic t_sync;
		offer(24'h0f0f0f);
		wait_rdy(1'b0);
		filter_sync_n = 1'b0;
		wait_rdy(1'b1);
		check(sync_hold, 1'b1);
		i_asp_host.xfer({8'h10, 24'h5a5a5a}, 0, rd);
		check(ctrl_regs[71:48], 24'h5a5a5a);
		check(ctrl_regs[47:24], 24'ha5c33c);
		filter_sync_n = 1'b1;
		repeat (10) @(negedge clk);
		check(sync_hold, 1'b0);
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		t_regs;
		t_conv;
		t_sync;
		test_done;
	end
endmodule // test_adc_serial_ready_sync_port
